// *** shared/embc_map.svh ***
// Constants of the external memory bank controller
// Functional notes
// - Eight banks decode a 1GB external space; banks 0-5 are 128MB each.
// - Banks 1-7 take 8/16/32 bit width; boot bank only 16/32.
// - Seven banks start at fixed addresses; bank 7 start moves with size.
// - Bank 7 starts right after bank 6 ends.
// - Boot bank is mapped at address zero.
// - Boot width taken from boot mode pins at reset.
// - Memory address zero shifts to A0, A1 or A2 per bus width.
// - SDRAM bank select comes from the top two address bits inside bank size.
// - With wait enabled, strobe held while wait input is low.
// - Wait input sampled from one clock before access time ends.
// - Strobe released the clock after wait first sampled high.
// - Write strobe stretched and released like output enable.
// - Bus request from master answered by driving grant low.
// - While granted, address, data and controls go high impedance.
// - Grant released after the master drops its request.
// - Little or big endian byte order chosen by software.
// - SDRAM banks support self-refresh and power-down entry.
// - Width code 00=8, 01=16, 10=32, 11 reserved; boot field read-only.
// - All counts are in bus clock cycles.
// - Byte-lane enable is write byte enable ANDed with output enable.
`ifndef EMBC_MAP_SVH
`define EMBC_MAP_SVH
`define EMBC_W8        2'h0
`define EMBC_W16       2'h1
`define EMBC_W32       2'h2
`define EMBC_BOOT_NAND 2'h0
`define EMBC_BOOT_16   2'h1
`define EMBC_BOOT_32   2'h2
`define EMBC_BANK6_TOP 3'h6
`define EMBC_STRAP_AGE 2'h2
`define EMBC_BA_BITS   2
`define EMBC_BASE_SEG  4'h0
`define EMBC_SIZE_MIN  3'h0
`define EMBC_SIZE_MAX  3'h6
`define EMBC_SIZE_LSB  21
`define EMBC_BANK_MSB  29
`define EMBC_BANK_LSB  27
`define EMBC_ONE_CYC   4'h1
`define EMBC_CS_IDLE   8'hff
`endif

// *** shared/embc_pkg.sv ***
// Types of the external memory bank controller
`default_nettype none
package embc_pkg;
    typedef enum logic [2:0] {
        EMBC_IDLE   = 3'b000,
        EMBC_ACCESS = 3'b001,
        EMBC_WAIT   = 3'b010,
        EMBC_GRANT  = 3'b011,
        EMBC_PWRDN  = 3'b100
    } embc_state_e;
    typedef logic [1:0] embc_width_t;
endpackage
`default_nettype wire

// *** hw/embc_decode.sv ***
// Bank decoder with flexible bank 6/7 boundary
`timescale 1ns/10ps
`default_nettype none
`include "embc_map.svh"
module embc_decode
    import embc_pkg::*;
(
    // Request address and bank 6/7 size code
    input  wire logic [29:0] addr,
    input  wire logic [2:0]  size67,
    // Bank index
    output logic      [2:0]  bank
);
    logic [29:0] b7_start;
    // Bank 7 begins one bank-6 size above the fixed bank 6 start
    always_comb
    begin
        b7_start = {`EMBC_BANK6_TOP, {`EMBC_BANK_LSB{1'b0}}} +
                   (30'h1 << (`EMBC_SIZE_LSB + 32'(size67)));
        if (addr[`EMBC_BANK_MSB:`EMBC_BANK_LSB] < `EMBC_BANK6_TOP)
            bank = addr[`EMBC_BANK_MSB:`EMBC_BANK_LSB];
        else if (addr < b7_start)
            bank = 3'h6;
        else
            bank = 3'h7;
    end
endmodule // embc_decode
`default_nettype wire

// *** hw/embc_top.sv ***
// External memory bank controller core
`timescale 1ns/10ps
`default_nettype none
`include "embc_map.svh"
module embc_top
    import embc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Internal request port
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [29:0] req_addr,
    input  wire logic [31:0] req_wdata,
    input  wire logic [3:0]  req_byte_en,
    output logic             req_done,
    output logic [31:0]      req_rdata,
    // Configuration
    input  wire logic [15:0] bank_width_cfg,
    input  wire logic [7:0]  bank_wait_enable,
    input  wire logic [7:0]  bank_byte_lane_mode,
    input  wire logic [3:0]  access_cycles,
    input  wire logic [2:0]  bank67_size,
    input  wire logic        big_endian,
    input  wire logic        sdram_self_refresh,
    input  wire logic        sdram_power_down,
    // Status
    output logic [1:0]       boot_bank_width_field,
    output logic [1:0]       boot_mode_latched,
    output logic             sdram_low_power,
    // Memory pins
    input  wire logic [1:0]  boot_mode_pins,
    input  wire logic        ext_stretch_n,
    output logic             boot_bank_select_n,
    output logic [7:1]       bank_select_n,
    output logic             output_enable_n,
    output logic             write_enable_n,
    output logic [3:0]       write_byte_enable_n,
    output logic [3:0]       byte_lane_enable_n,
    output logic [26:0]      mem_addr,
    output logic [1:0]       sdram_bank_addr,
    output logic [31:0]      data_out,
    output logic             data_oe,
    input  wire logic [31:0] data_in,
    output logic             bus_oe,
    // External master arbitration
    input  wire logic        ext_bus_request_n,
    output logic             ext_bus_grant_n
);
    embc_state_e state_r;
    embc_state_e state_nxt;
    logic [3:0]  cnt_r;
    logic [2:0]  bank;
    logic [2:0]  bank_r;
    logic [1:0]  wait_s1_r;
    logic [1:0]  req_s1_r;
    logic        stretch_s1_r;
    logic        stretch_r;
    logic        breq_s1_r;
    logic        breq_r;
    logic        strap_pend_r;
    logic [1:0]  strap_age_r;
    logic [2:0]  sel_bank;
    logic        oe_nxt_n;
    logic [3:0]  wbe_nxt_n;
    logic        wr_r;
    logic [1:0]  eff_width;

    // Width of a bank; boot bank follows the strap, reserved maps to 32
    function automatic embc_width_t width_of(input logic [2:0] b, input logic [15:0] cfg,
                                              input logic [1:0] boot);
        embc_width_t w;
        w = (b == 3'h0) ? boot : cfg[2*b +: 2];
        if (w == 2'h3)
            w = `EMBC_W32;
        return w;
    endfunction

    // Byte swap for big endian 32-bit words
    function automatic logic [31:0] swap(input logic [31:0] d, input logic be);
        return be ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction

    // Active-low byte enables in pin order; big endian mirrors the lanes
    function automatic logic [3:0] wbe_of(input logic [3:0] en, input logic be);
        return ~(be ? {en[0], en[1], en[2], en[3]} : en);
    endfunction

    embc_decode u_decode (
        .addr   (req_addr),
        .size67 (bank67_size),
        .bank   (bank)
    );

    assign eff_width = width_of(bank, bank_width_cfg, boot_bank_width_field);

    // Bank and strobe levels that the next edge drives
    always_comb
    begin
        sel_bank  = (state_r == EMBC_IDLE) ? bank : bank_r;
        oe_nxt_n  = (state_r == EMBC_IDLE) ? req_write : wr_r;
        wbe_nxt_n = (state_r == EMBC_IDLE) ? wbe_of(req_byte_en, big_endian) :
                    write_byte_enable_n;
    end

    // Two-stage synchronisers for pins
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stretch_s1_r <= 1'b1;
            stretch_r    <= 1'b1;
            breq_s1_r    <= 1'b1;
            breq_r       <= 1'b1;
            wait_s1_r    <= 2'h0;
            req_s1_r     <= 2'h0;
        end
        else
        begin
            stretch_s1_r <= ext_stretch_n;
            stretch_r    <= stretch_s1_r;
            breq_s1_r    <= ext_bus_request_n;
            breq_r       <= breq_s1_r;
            wait_s1_r    <= boot_mode_pins;
            req_s1_r     <= wait_s1_r;
        end
    end

    // Boot strap captured once the synchroniser holds post-reset pin levels
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_pend_r          <= 1'b1;
            strap_age_r           <= 2'h0;
            boot_mode_latched     <= 2'h0;
            boot_bank_width_field <= `EMBC_W16;
        end
        else if (strap_pend_r && strap_age_r != `EMBC_STRAP_AGE)
            strap_age_r <= strap_age_r + 2'h1;
        else if (strap_pend_r)
        begin
            strap_pend_r      <= 1'b0;
            boot_mode_latched <= req_s1_r;
            boot_bank_width_field <= (req_s1_r == `EMBC_BOOT_32) ? `EMBC_W32 : `EMBC_W16;
        end
    end

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            EMBC_IDLE:
                if (!breq_r)
                    state_nxt = EMBC_GRANT;
                else if (sdram_self_refresh || sdram_power_down)
                    state_nxt = EMBC_PWRDN;
                else if (req_valid && !strap_pend_r)
                    state_nxt = EMBC_ACCESS;
            EMBC_ACCESS:
                if (cnt_r <= `EMBC_ONE_CYC)
                    state_nxt = (bank_wait_enable[bank_r] && !stretch_r) ?
                                EMBC_WAIT : EMBC_IDLE;
            EMBC_WAIT:
                if (stretch_r)
                    state_nxt = EMBC_IDLE;
            EMBC_GRANT:
                if (breq_r)
                    state_nxt = EMBC_IDLE;
            EMBC_PWRDN:
                if (!sdram_self_refresh && !sdram_power_down)
                    state_nxt = EMBC_IDLE;
            default:
                state_nxt = EMBC_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= EMBC_IDLE;
        else
            state_r <= state_nxt;
    end

    // Access cycle counter in bus clocks
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= 4'h0;
        else if (state_r == EMBC_IDLE && state_nxt == EMBC_ACCESS)
            cnt_r <= (access_cycles == 4'h0) ? `EMBC_ONE_CYC : access_cycles;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end

    // Access latch: bank, address, data, strobes
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bank_r              <= 3'h0;
            wr_r                <= 1'b0;
            mem_addr            <= 27'h0;
            sdram_bank_addr     <= 2'h0;
            data_out            <= 32'h0;
            write_byte_enable_n <= 4'hf;
        end
        else if (state_r == EMBC_IDLE && state_nxt == EMBC_ACCESS)
        begin
            bank_r   <= bank;
            wr_r     <= req_write;
            mem_addr <= req_addr[26:0] >> eff_width;
            // Top bank bit is the highest address line inside the bank size
            sdram_bank_addr <= 2'(req_addr[29:0] >> (`EMBC_SIZE_LSB - `EMBC_BA_BITS +
                               32'(bank67_size)));
            data_out <= swap(req_wdata, big_endian);
            write_byte_enable_n <= wbe_of(req_byte_en, big_endian);
        end
    end

    // Pin strobes, selects and bus release
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_bank_select_n <= 1'b1;
            bank_select_n      <= 7'h7f;
            output_enable_n    <= 1'b1;
            write_enable_n     <= 1'b1;
            byte_lane_enable_n <= 4'hf;
            data_oe            <= 1'b0;
            bus_oe             <= 1'b1;
            ext_bus_grant_n    <= 1'b1;
            sdram_low_power    <= 1'b0;
        end
        else
        begin
            if (state_nxt == EMBC_ACCESS || state_nxt == EMBC_WAIT)
            begin
                boot_bank_select_n <= (state_r == EMBC_IDLE ? bank : bank_r) != 3'h0;
                bank_select_n <= ~(7'((8'h1 << (state_r == EMBC_IDLE ? bank : bank_r))
                                   >> 1));
                output_enable_n <= (state_r == EMBC_IDLE) ? req_write : wr_r;
                write_enable_n  <= (state_r == EMBC_IDLE) ? !req_write : !wr_r;
                data_oe <= (state_r == EMBC_IDLE) ? req_write : wr_r;
                byte_lane_enable_n <= bank_byte_lane_mode[sel_bank] ?
                    (wbe_nxt_n & {4{oe_nxt_n}}) : 4'hf;
            end
            else
            begin
                boot_bank_select_n <= 1'b1;
                bank_select_n      <= 7'h7f;
                output_enable_n    <= 1'b1;
                write_enable_n     <= 1'b1;
                byte_lane_enable_n <= 4'hf;
                data_oe            <= 1'b0;
            end
            bus_oe          <= state_nxt != EMBC_GRANT;
            ext_bus_grant_n <= state_nxt != EMBC_GRANT;
            sdram_low_power <= state_nxt == EMBC_PWRDN;
        end
    end

    // Read data capture and completion pulse
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_done  <= 1'b0;
            req_rdata <= 32'h0;
        end
        else
        begin
            req_done <= (state_r == EMBC_ACCESS || state_r == EMBC_WAIT) &&
                        state_nxt == EMBC_IDLE;
            if ((state_r == EMBC_ACCESS || state_r == EMBC_WAIT) &&
                state_nxt == EMBC_IDLE && !wr_r)
                req_rdata <= swap(data_in, big_endian);
        end
    end

    // Grant only from idle, so a running access completes first
    property p_grant_after_idle;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(ext_bus_grant_n) |-> $past(state_r) == EMBC_IDLE;
    endproperty
    a_grant_after_idle: assert property (p_grant_after_idle) else $error("grant mid access");

    property p_hiz_when_granted;
        @(posedge core_clk) disable iff (!rst_n)
        !ext_bus_grant_n |-> !bus_oe && !data_oe && output_enable_n && write_enable_n;
    endproperty
    a_hiz_when_granted: assert property (p_hiz_when_granted) else $error("bus driven in grant");

    property p_grant_on_request;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == EMBC_IDLE && !breq_r) |=> !ext_bus_grant_n;
    endproperty
    a_grant_on_request: assert property (p_grant_on_request) else $error("no grant");

    property p_grant_release;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == EMBC_GRANT && breq_r) |=> ext_bus_grant_n;
    endproperty
    a_grant_release: assert property (p_grant_release) else $error("grant held");

    property p_one_select;
        @(posedge core_clk) disable iff (!rst_n)
        $countones({~bank_select_n, ~boot_bank_select_n}) <= 1;
    endproperty
    a_one_select: assert property (p_one_select) else $error("several selects");

    property p_wait_holds_oe;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == EMBC_WAIT && !stretch_r) |=> (!output_enable_n || !write_enable_n);
    endproperty
    a_wait_holds_oe: assert property (p_wait_holds_oe) else $error("strobe dropped");

    property p_release_after_high;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == EMBC_WAIT && stretch_r) |=> output_enable_n && write_enable_n;
    endproperty
    a_release_after_high: assert property (p_release_after_high) else $error("late release");

    property p_boot_width;
        @(posedge core_clk) disable iff (!rst_n)
        boot_bank_width_field != `EMBC_W8;
    endproperty
    a_boot_width: assert property (p_boot_width) else $error("boot width 8");

    property p_lanes;
        @(posedge core_clk) disable iff (!rst_n)
        (!output_enable_n || !write_enable_n) && bank_byte_lane_mode[bank_r] |->
            byte_lane_enable_n == (write_byte_enable_n & {4{output_enable_n}});
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane enable mismatch");

    c_read:  cover property (@(posedge core_clk) state_r == EMBC_ACCESS && !wr_r);
    c_write: cover property (@(posedge core_clk) state_r == EMBC_ACCESS && wr_r);
    c_wait:  cover property (@(posedge core_clk) state_r == EMBC_WAIT);
    c_grant: cover property (@(posedge core_clk) !ext_bus_grant_n);
endmodule // embc_top
`default_nettype wire

// *** bench/embc_mem_model.sv ***
// Memory device model that answers the bank controller's strobes
`timescale 1ns/10ps
`default_nettype none
module embc_mem_model (
    // Clock and memory pins
    input  wire logic        core_clk,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic [26:0] mem_addr,
    // Stall length chosen by the bench
    input  wire logic [7:0]  stall,
    // Answer lines
    output logic             ext_stretch_n,
    output logic [31:0]      data_in
);
    logic [7:0]  cnt_r = 8'h0;
    logic [31:0] last_r = 32'h0;
    logic        idle;

    // Strobe state of the device
    assign idle = output_enable_n & write_enable_n;

    // Wait line held low for a stall after a strobe falls, pulled up otherwise
    always_ff @(posedge core_clk)
    begin
        if (idle)
            cnt_r <= stall;
        else if (cnt_r != 8'h0)
            cnt_r <= cnt_r - 8'h1;
    end
    assign ext_stretch_n = idle | (cnt_r == 8'h0);

    // Read data from the address; a released bus toggles every cycle
    always_ff @(posedge core_clk)
    begin
        last_r <= data_in;
    end
    assign data_in = output_enable_n ? ~last_r : {~mem_addr[15:0], mem_addr[15:0]};
endmodule // embc_mem_model
`default_nettype wire

// *** bench/embc_tb_top.sv ***
// Self-checking testbench of the external memory bank controller
`timescale 1ns/10ps
`default_nettype none
module embc_tb_top;
    import embc_pkg::*;
    // Stimulus
    logic        core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [29:0] req_addr = 30'h0;
    logic [31:0] req_wdata = 32'h0;
    logic [3:0]  req_byte_en = 4'hf, access_cycles = 4'h1;
    logic [15:0] bank_width_cfg = 16'h0;
    logic [7:0]  bank_wait_enable = 8'h0, bank_byte_lane_mode = 8'h0, stall = 8'h0;
    logic [2:0]  bank67_size = 3'h0;
    logic        big_endian = 1'b0, sdram_self_refresh = 1'b0, sdram_power_down = 1'b0;
    logic [1:0]  boot_mode_pins = 2'h1;
    logic        ext_bus_request_n = 1'b1;
    // Observed
    logic        req_done, sdram_low_power, ext_stretch_n, boot_bank_select_n;
    logic        output_enable_n, write_enable_n, data_oe, bus_oe, ext_bus_grant_n;
    logic [31:0] req_rdata, data_out, data_in, dq;
    logic [1:0]  boot_bank_width_field, boot_mode_latched, sdram_bank_addr;
    logic [7:1]  bank_select_n;
    logic [3:0]  write_byte_enable_n, byte_lane_enable_n, wb;
    logic [26:0] mem_addr, ma;
    logic [7:0]  sel, cs;
    int          n_fail = 0, samples_checked = 0, lo;

    // Clock of 25 ns
    always #12.5 core_clk = ~core_clk;

    embc_top dut (
        .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en),
        .req_done(req_done), .req_rdata(req_rdata), .bank_width_cfg(bank_width_cfg),
        .bank_wait_enable(bank_wait_enable), .bank_byte_lane_mode(bank_byte_lane_mode),
        .access_cycles(access_cycles), .bank67_size(bank67_size), .big_endian(big_endian),
        .sdram_self_refresh(sdram_self_refresh), .sdram_power_down(sdram_power_down),
        .boot_bank_width_field(boot_bank_width_field), .boot_mode_latched(boot_mode_latched),
        .sdram_low_power(sdram_low_power), .boot_mode_pins(boot_mode_pins),
        .ext_stretch_n(ext_stretch_n), .boot_bank_select_n(boot_bank_select_n),
        .bank_select_n(bank_select_n), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .write_byte_enable_n(write_byte_enable_n),
        .byte_lane_enable_n(byte_lane_enable_n), .mem_addr(mem_addr),
        .sdram_bank_addr(sdram_bank_addr),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .bus_oe(bus_oe),
        .ext_bus_request_n(ext_bus_request_n), .ext_bus_grant_n(ext_bus_grant_n)
    );

    embc_mem_model mem (
        .core_clk(core_clk), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .mem_addr(mem_addr), .stall(stall),
        .ext_stretch_n(ext_stretch_n), .data_in(data_in)
    );

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Reset held six cycles
    task automatic rst();
        rst_n = 1'b0;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge core_clk);
    endtask

    // Expected bank from address and bank 6/7 size
    function automatic int xbank(logic [29:0] a);
        if (a[29:27] < 3'h6)
            return int'(a[29:27]);
        return (a < 30'h3000_0000 + (30'h20_0000 << bank67_size)) ? 6 : 7;
    endfunction

    // Expected address shift; strap is left at a 16-bit code
    function automatic int xsh(int b);
        logic [1:0] f;
        f = (b == 0) ? 2'h1 : bank_width_cfg[2*b +: 2];
        return (f == 2'h0) ? 0 : (f == 2'h1) ? 1 : 2;
    endfunction

    // Byte order swap
    function automatic logic [31:0] sw(logic [31:0] d);
        return big_endian ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction

    // One access, watching pins every cycle until done
    task automatic acc(input logic [29:0] a, input logic w);
        int  n;
        logic st;
        @(negedge core_clk);
        req_addr = a;
        req_write = w;
        req_valid = 1'b1;
        lo = 0;
        sel = 8'hff;
        for (n = 0; n < 400 && req_done !== 1'b1; n++)
        begin
            @(negedge core_clk);
            st = w ? write_enable_n : output_enable_n;
            cs = ~{bank_select_n, boot_bank_select_n};
            lo += int'(st === 1'b0);
            if (st === 1'b0)
            begin
                sel = ~cs;
                ma = mem_addr;
                dq = data_out;
                wb = write_byte_enable_n;
            end
            chk("one_select", 1, $countones(cs) <= 1);
            chk("grant_in_access", 1, ext_bus_grant_n | st);
            if ((cs & bank_byte_lane_mode) != 8'h0)
                chk("lanes", write_byte_enable_n & {4{output_enable_n}}, byte_lane_enable_n);
        end
        chk("done", 1, req_done);
        req_valid = 1'b0;
    endtask

    // Random access with its expectations
    task automatic one(input logic [29:0] a);
        int   b, sh;
        logic w;
        logic [3:0] e;
        w = 1'($urandom());
        req_wdata = $urandom();
        req_byte_en = 4'($urandom()) | 4'h1;
        big_endian = 1'($urandom());
        access_cycles = 4'($urandom());
        bank_byte_lane_mode = 8'($urandom());
        b = xbank(a);
        sh = xsh(b);
        e = req_byte_en;
        acc(a, w);
        chk("select", 8'(~(8'h1 << b)), sel);
        chk("strobe_len", (access_cycles == 4'h0) ? 1 : access_cycles, lo);
        chk("mem_addr", 24'(a >> sh), ma[23:0]);
        chk("sdram_bank", 2'(a >> (19 + bank67_size)), sdram_bank_addr);
        if (sh == 2 && !w)
            chk("read_data", sw({~a[17:2], a[17:2]}), req_rdata);
        if (sh == 2 && w)
            chk("write_data", sw(req_wdata), dq);
        if (sh == 2 && w)
            chk("byte_en", 4'(~(big_endian ? {e[0], e[1], e[2], e[3]} : e)), wb);
    endtask

    // Hang guard
    initial
    begin
        #(25ns * 30000);
        chk("watchdog", 0, 1);
        test_done();
    end

    initial
    begin
        int n;
        void'($urandom(32'had20fcb5));
        // Every strap code across resets
        for (int p = 0; p < 4; p++)
        begin
            boot_mode_pins = p[1:0];
            rst();
            chk("boot_width", (p == 2) ? 2'h2 : 2'h1, boot_bank_width_field);
            chk("boot_latched", p, boot_mode_latched);
            chk("idle_pins", 1, ext_bus_grant_n & output_enable_n & write_enable_n);
        end
        // Bank 6/7 boundary at every size, then boot bank at zero
        for (int s = 0; s < 7; s++)
        begin
            bank67_size = s[2:0];
            one(30'h3000_0000 + (30'h20_0000 << s) - 30'h4);
            one(30'h3000_0000 + (30'h20_0000 << s));
        end
        one(30'h0);
        // Random traffic over all banks and widths
        repeat (40)
        begin
            bank_width_cfg = 16'($urandom());
            bank67_size = 3'($urandom() % 7);
            one(30'($urandom()) & 30'h3fff_fffc);
        end
        // Wait line stretches both strobes only when enabled
        access_cycles = 4'h4;
        stall = 8'd12;
        for (int k = 0; k < 4; k++)
        begin
            bank_wait_enable = k[1] ? 8'hff : 8'h00;
            acc(30'h0800_0000, k[0]);
            if (k[1])
                chk("stretch", 1, lo >= 12 && lo <= 18);
            else
                chk("no_stretch", 4, lo);
        end
        stall = 8'h0;
        // Master asks for the bus in mid-access
        access_cycles = 4'h6;
        fork
            acc(30'h1000_0000, 1'b0);
            begin
                repeat (3) @(negedge core_clk);
                ext_bus_request_n = 1'b0;
            end
        join
        for (n = 0; n < 20 && ext_bus_grant_n !== 1'b0; n++) @(negedge core_clk);
        chk("grant", 0, ext_bus_grant_n);
        chk("float", 0, {bus_oe, data_oe});
        fork
            acc(30'h1800_0000, 1'b1);
            begin
                repeat (6) @(negedge core_clk);
                chk("refused", 8'hff, {bank_select_n, boot_bank_select_n});
                ext_bus_request_n = 1'b1;
            end
        join
        chk("grant_off", 1, ext_bus_grant_n & bus_oe);
        // Self-refresh and power-down entry and exit
        for (int k = 0; k < 2; k++)
        begin
            {sdram_power_down, sdram_self_refresh} = k[0] ? 2'b10 : 2'b01;
            for (n = 0; n < 20 && sdram_low_power !== 1'b1; n++) @(negedge core_clk);
            chk("low_power", 1, sdram_low_power);
            {sdram_power_down, sdram_self_refresh} = 2'b00;
            for (n = 0; n < 20 && sdram_low_power !== 1'b0; n++) @(negedge core_clk);
            chk("low_power_exit", 0, sdram_low_power);
        end
        test_done();
    end
endmodule // embc_tb_top
`default_nettype wire
